/* File: rtl/qdw_dac_serial.sv */
// Serial write path of a quad converter: link receiver, word buffer and channel registers.
//
// Operation
// - The input shift register is exactly 16 bits; an update is one whole word.
// - The word arrives as two consecutive bytes while frame select stays low.
// - Bits travel most significant first on the link.
// - Serial clock periods down to 8 system cycles (31.25 MHz) are accepted; faster ones are flagged.
// - Frame select is an active-low chip select framing each transfer.
// - Upper byte: address 7:6, power-down bit 5, load bit 4, sample 3:0.
`timescale 1ns/1ns
module qdw_dac_serial
   import qdw_pkg::*;
(
   input  wire logic                               sys_clk,         // System clock, 250 MHz.
   input  wire logic                               nrst,            // Asynchronous reset.
   input  wire logic                               link_sclk,       // Serial clock pin.
   input  wire logic                               link_din,        // Serial data pin.
   input  wire logic                               link_frame_n,    // Frame select pin.
   input  wire logic                               apply_hold,      // Stalls word application.
   output logic [NUM_CH-1:0][SAMPLE_W-1:0]         dac_code,        // Active output codes.
   output logic [NUM_CH-1:0][SAMPLE_W-1:0]         input_code,      // Staged input codes.
   output logic                                    powered_up,      // Outputs powered.
   output logic                                    word_pending,    // Buffered word waiting.
   output logic                                    frame_dropped,   // Word lost, buffer full.
   output logic                                    frame_short,     // Frame not 16 bits.
   output logic                                    rate_fault       // Clock above limit.
);

   // Pin synchronisers: the first stage feeds only the second.
   qdw_pins_s  pins_meta;
   qdw_pins_s  pins_sync;
   qdw_pins_s  pins_prev;
   qdw_pins_s  pins_raw;

   assign pins_raw = '{sclk: link_sclk, din: link_din, frame_n: link_frame_n};

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         pins_meta <= '{sclk: 1'b1, din: 1'b0, frame_n: 1'b1};
         pins_sync <= '{sclk: 1'b1, din: 1'b0, frame_n: 1'b1};
         pins_prev <= '{sclk: 1'b1, din: 1'b0, frame_n: 1'b1};
      end else begin
         pins_meta <= pins_raw;
         pins_sync <= pins_meta;
         pins_prev <= pins_sync;
      end
   end

   logic sclk_fall;
   logic frame_start;
   logic frame_end;

   // Data is taken on the falling serial clock edge, inside a low frame select.
   assign sclk_fall   = pins_prev.sclk && !pins_sync.sclk;
   assign frame_start = pins_prev.frame_n && !pins_sync.frame_n;
   assign frame_end   = !pins_prev.frame_n && pins_sync.frame_n;

   // Receiver state.
   qdw_state_e            state;
   qdw_state_e            next_state;
   logic [WORD_W-1:0]     shift;
   logic [WORD_W-1:0]     next_shift;
   logic [4:0]            count;
   logic [4:0]            next_count;
   logic [GAP_W-1:0]      gap;
   logic [GAP_W-1:0]      next_gap;
   logic                  seen_fall;
   logic                  next_seen_fall;
   logic                  next_rate_fault;
   logic                  next_frame_dropped;
   logic                  next_frame_short;
   logic                  push;
   logic                  buf_in_ready;

   always_comb begin
      next_state         = state;
      next_shift         = shift;
      next_count         = count;
      next_gap           = gap;
      next_seen_fall     = seen_fall;
      next_rate_fault    = rate_fault;
      next_frame_dropped = frame_dropped;
      next_frame_short   = frame_short;
      push               = 1'b0;
      if (gap != GAP_MAX) begin
         next_gap = gap + GAP_ONE;
      end
      case (state)
         QDW_IDLE: begin
            if (frame_start) begin
               next_state         = QDW_SHIFT;
               next_count         = COUNT_ZERO;
               next_seen_fall     = 1'b0;
               next_rate_fault    = 1'b0;
               next_frame_dropped = 1'b0;
               next_frame_short   = 1'b0;
            end
         end
         QDW_SHIFT: begin
            if (frame_end) begin
               next_state = QDW_IDLE;
               if (count == WORD_BITS) begin
                  push = 1'b1;
                  if (!buf_in_ready) begin
                     next_frame_dropped = 1'b1;
                  end
               end else begin
                  next_frame_short = 1'b1;
               end
            end else if (sclk_fall) begin
               // Bits beyond the sixteenth are ignored; the frame then reads as short.
               if (count < WORD_BITS) begin
                  next_shift = {shift[WORD_W-2:0], pins_sync.din};
                  next_count = count + COUNT_ONE;
               end else begin
                  next_count = WORD_BITS + COUNT_ONE;
               end
               // The gap counter lags the fall spacing by one cycle, hence the minus one.
               if (seen_fall && (gap < (SCLK_MIN_CYC - GAP_ONE))) begin
                  next_rate_fault = 1'b1;
               end
               next_seen_fall = 1'b1;
               next_gap       = GAP_ZERO;
            end
         end
         default: begin
            next_state = QDW_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         state         <= QDW_IDLE;
         shift         <= '0;
         count         <= COUNT_ZERO;
         gap           <= GAP_ZERO;
         seen_fall     <= 1'b0;
         rate_fault    <= 1'b0;
         frame_dropped <= 1'b0;
         frame_short   <= 1'b0;
      end else begin
         state         <= next_state;
         shift         <= next_shift;
         count         <= next_count;
         gap           <= next_gap;
         seen_fall     <= next_seen_fall;
         rate_fault    <= next_rate_fault;
         frame_dropped <= next_frame_dropped;
         frame_short   <= next_frame_short;
      end
   end

   // Completed words wait here so a held apply stage loses none of up to two.
   qdw_word_s buf_word;
   logic      buf_out_valid;
   logic      take;

   qdw_word_buf #(
      .W     (WORD_W),
      .DEPTH (2)
   ) u_word_buf (
      .sys_clk   (sys_clk),
      .nrst      (nrst),
      .in_valid  (push),
      .in_ready  (buf_in_ready),
      .in_data   (shift),
      .out_valid (buf_out_valid),
      .out_ready (!apply_hold),
      .out_data  (buf_word)
   );

   assign take         = buf_out_valid && !apply_hold;
   assign word_pending = buf_out_valid;

   // Power state follows the power-down bit of each applied word, clear meaning off.
   logic next_powered_up;

   always_comb begin
      next_powered_up = powered_up;
      if (take) begin
         next_powered_up = buf_word.power_down_bit;
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         powered_up <= POWERED_RESET;
      end else begin
         powered_up <= next_powered_up;
      end
   end

   // Per-channel staging and active registers.
   for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
      logic [SAMPLE_W-1:0] next_input;
      logic [SAMPLE_W-1:0] next_code;
      logic                hit;

      assign hit = (buf_word.channel_address == CH_ADDR_W'(ch));

      always_comb begin
         next_input = input_code[ch];
         next_code  = dac_code[ch];
         if (take && hit) begin
            next_input = buf_word.sample;
         end
         // A set load bit moves every staged code, the new one included, to the outputs.
         if (take && buf_word.load_outputs_bit) begin
            next_code = next_input;
         end
      end

      always_ff @(posedge sys_clk or negedge nrst) begin
         if (!nrst) begin
            input_code[ch] <= SAMPLE_RESET;
            dac_code[ch]   <= SAMPLE_RESET;
         end else begin
            input_code[ch] <= next_input;
            dac_code[ch]   <= next_code;
         end
      end
   end

endmodule // qdw_dac_serial

/* File: pkg/qdw_pkg.sv */
// Shared constants and types for the quad converter serial write path.
package qdw_pkg;

   // Serial word layout, most significant bit first.
   localparam int           WORD_W     = 16;
   localparam int           BYTE_W     = 8;
   localparam int           SAMPLE_W   = 12;
   localparam int           NUM_CH     = 4;
   localparam int           CH_ADDR_W  = 2;
   localparam logic [4:0]   WORD_BITS  = 5'h10;
   localparam logic [4:0]   COUNT_ZERO = 5'h00;
   localparam logic [4:0]   COUNT_ONE  = 5'h01;

   // Upper byte field masks as the host builds them.
   localparam logic [7:0]   UPPER_PD_MASK   = 8'h20;
   localparam logic [7:0]   UPPER_LOAD_MASK = 8'h10;

   // Reset values of the converter state.
   localparam logic [11:0]  SAMPLE_RESET  = 12'h000;
   localparam logic         POWERED_RESET = 1'b0;

   // Timing: system clock and the serial clock rate the shortest period is derived from.
   localparam int           SYS_CLK_KHZ    = 250000;
   localparam int           SCLK_MAX_KHZ   = 30000;
   // Shortest serial clock period, rounded down to whole system cycles.
   localparam int           SCLK_MIN_CYC_I = SYS_CLK_KHZ / SCLK_MAX_KHZ;
   localparam int           GAP_W          = 4;
   localparam logic [3:0]   SCLK_MIN_CYC   = 4'(SCLK_MIN_CYC_I);
   localparam logic [3:0]   GAP_ZERO       = 4'h0;
   localparam logic [3:0]   GAP_ONE        = 4'h1;
   localparam logic [3:0]   GAP_MAX        = 4'hf;

   // One 16-bit word as it arrives on the link.
   typedef struct packed {
      logic [1:0]  channel_address;
      logic        power_down_bit;
      logic        load_outputs_bit;
      logic [11:0] sample;
   } qdw_word_s;

   // Serial pins after synchronisation.
   typedef struct packed {
      logic sclk;
      logic din;
      logic frame_n;
   } qdw_pins_s;

   typedef enum logic [0:0] {
      QDW_IDLE,
      QDW_SHIFT
   } qdw_state_e;

endpackage

/* File: rtl/qdw_word_buf.sv */
// Two-entry word buffer with valid and ready on both sides.
`timescale 1ns/1ns
module qdw_word_buf #(
   parameter int W     = 16,
   parameter int DEPTH = 2
) (
   input  wire logic         sys_clk,   // System clock.
   input  wire logic         nrst,      // Asynchronous reset, active low.
   input  wire logic         in_valid,  // Word offered.
   output logic              in_ready,  // Room for a word.
   input  wire logic [W-1:0] in_data,   // Offered word.
   output logic              out_valid, // Word waiting.
   input  wire logic         out_ready, // Drain side takes the word.
   output logic [W-1:0]      out_data   // Oldest word.
);

   logic [DEPTH-1:0][W-1:0] mem;
   logic [DEPTH-1:0][W-1:0] next_mem;
   logic                    wr_ptr;
   logic                    next_wr_ptr;
   logic                    rd_ptr;
   logic                    next_rd_ptr;
   logic [1:0]              fill;
   logic [1:0]              next_fill;
   logic                    do_wr;
   logic                    do_rd;

   assign in_ready  = (fill != 2'(DEPTH));
   assign out_valid = (fill != 2'h0);
   assign out_data  = mem[rd_ptr];
   assign do_wr     = in_valid && in_ready;
   assign do_rd     = out_valid && out_ready;

   always_comb begin
      next_mem    = mem;
      next_wr_ptr = wr_ptr;
      next_rd_ptr = rd_ptr;
      next_fill   = fill;
      if (do_wr) begin
         next_mem[wr_ptr] = in_data;
         next_wr_ptr      = ~wr_ptr;
      end
      if (do_rd) begin
         next_rd_ptr = ~rd_ptr;
      end
      if (do_wr && !do_rd) begin
         next_fill = fill + 2'h1;
      end else if (do_rd && !do_wr) begin
         next_fill = fill - 2'h1;
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         mem    <= '0;
         wr_ptr <= 1'b0;
         rd_ptr <= 1'b0;
         fill   <= 2'h0;
      end else begin
         mem    <= next_mem;
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         fill   <= next_fill;
      end
   end

endmodule // qdw_word_buf

/* File: dv/qdw_dac_serial_chk.sv */
// Port assertions for the quad converter serial write path.
`timescale 1ns/1ns
module qdw_dac_serial_chk
   import qdw_pkg::*;
(
   input wire logic                             sys_clk,       // Clock.
   input wire logic                             nrst,          // Reset.
   input wire logic                             link_frame_n,  // Frame select.
   input wire logic                             apply_hold,    // Stall.
   input wire logic [NUM_CH-1:0][SAMPLE_W-1:0] dac_code,      // Outputs.
   input wire logic [NUM_CH-1:0][SAMPLE_W-1:0] input_code,    // Staged.
   input wire logic                             powered_up,    // Power.
   input wire logic                             word_pending,  // Waiting.
   input wire logic                             frame_dropped, // Lost.
   input wire logic                             frame_short,   // Short.
   input wire logic                             rate_fault     // Too fast.
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   AST_RESET_CLEAN: assert property ($rose(nrst) |-> dac_code == '0 && input_code == '0
      && !powered_up && !word_pending) else $error("outputs not clear after reset");
   AST_DAC_COPY: assert property (!$stable(dac_code) |-> dac_code == input_code)
      else $error("output codes changed without a full copy");
   AST_IN_CAUSE: assert property (!$stable(input_code) |-> $past(word_pending)
      || $past(word_pending, 2)) else $error("staged code changed with no word");
   AST_PWR_CAUSE: assert property (!$stable(powered_up) |-> $past(word_pending)
      || $past(word_pending, 2)) else $error("power state changed with no word");
   AST_HOLD_STALL: assert property ((apply_hold || !word_pending)[*2] |=>
      $stable(input_code) && $stable(dac_code)) else $error("update during stall");
   AST_DRAIN: assert property (word_pending && !apply_hold |-> ##[1:3]
      (!word_pending || apply_hold)) else $error("buffered word not applied");
   AST_PUSH_AT_END: assert property ($rose(word_pending) |-> link_frame_n
      && $past(link_frame_n, 2)) else $error("word taken inside a frame");
   AST_FLAG_CLEAR: assert property ($fell(link_frame_n) |-> ##[3:6] (!frame_short
      && !frame_dropped && !rate_fault)) else $error("flags not cleared at frame start");
   AST_SHORT_END: assert property ($rose(frame_short) |-> link_frame_n)
      else $error("short frame flagged inside a frame");
   AST_DROP_FULL: assert property ($rose(frame_dropped) |-> word_pending)
      else $error("word dropped with buffer room");
   AST_RATE_IN_FRAME: assert property ($rose(rate_fault) |-> !$past(link_frame_n, 3))
      else $error("rate fault outside a frame");
endmodule // qdw_dac_serial_chk

bind qdw_dac_serial qdw_dac_serial_chk u_chk (.sys_clk(sys_clk), .nrst(nrst),
   .link_frame_n(link_frame_n), .apply_hold(apply_hold), .dac_code(dac_code),
   .input_code(input_code), .powered_up(powered_up), .word_pending(word_pending),
   .frame_dropped(frame_dropped), .frame_short(frame_short), .rate_fault(rate_fault));

/* File: dv/qdw_host.sv */
// Serial host model that frames words onto the link.
`timescale 1ns/1ns
module qdw_host (
   output logic sclk,    // Serial clock.
   output logic din,     // Serial data.
   output logic frame_n  // Frame select.
);
   logic byte_done; // Host per-byte completion flag.
   initial begin
      sclk = 1'b1;
      frame_n = 1'b1;
      din = 1'b0;
      byte_done = 1'b0;
   end
   // Sends the low n bits of w, top bit first, with half period h in ns.
   task automatic xfer(input logic [16:0] w, input int n, input int h);
      frame_n = 1'b0;
      #20;
      for (int i = n - 1; i >= 0; i--) begin
         if ((n - 1 - i) % 8 == 0) byte_done = 1'b0;
         din = w[i];
         #h sclk = 1'b0;
         #h sclk = 1'b1;
         if ((n - i) % 8 == 0) byte_done = 1'b1;
      end
      if (n % 8 == 0) wait (byte_done);
      #h frame_n = 1'b1;
      din = ~din;
   endtask
endmodule // qdw_host

/* File: dv/qdw_dac_serial_bench.sv */
// Self-checking bench for the quad converter serial write path.
`timescale 1ns/1ns
module qdw_dac_serial_bench
   import qdw_pkg::*;
;
   logic                            sys_clk = 1'b0;
   logic                            nrst, apply_hold, sclk, din, frame_n, exp_pu;
   logic                            powered_up, word_pending, frame_dropped;
   logic                            frame_short, rate_fault;
   logic [NUM_CH-1:0][SAMPLE_W-1:0] dac_code, input_code, exp_in, exp_dac;
   logic [16:0]                     w, hw [2];
   int                              n_mismatch = 0;
   int                              n_tests = 0;

   always #2 sys_clk = ~sys_clk;

   qdw_host hst (.sclk(sclk), .din(din), .frame_n(frame_n));
   qdw_dac_serial DUT (.sys_clk(sys_clk), .nrst(nrst), .link_sclk(sclk), .link_din(din),
      .link_frame_n(frame_n), .apply_hold(apply_hold), .dac_code(dac_code),
      .input_code(input_code), .powered_up(powered_up), .word_pending(word_pending),
      .frame_dropped(frame_dropped), .frame_short(frame_short), .rate_fault(rate_fault));

   task automatic check(input logic [47:0] seen, input logic [47:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   function automatic logic [16:0] mk(input logic [1:0] ch, input logic pd,
                                      input logic ld, input logic [11:0] s);
      logic [7:0] up;
      up = {ch, 6'h00} | (pd ? UPPER_PD_MASK : 8'h00) | (ld ? UPPER_LOAD_MASK : 8'h00)
         | {4'h0, s[11:8]};
      return {1'b0, up, s[7:0]};
   endfunction

   task automatic upd(input logic [16:0] x);
      exp_in[x[15:14]] = x[11:0];
      exp_pu = x[13];
      if (x[12]) exp_dac = exp_in;
   endtask

   task automatic send(input logic [16:0] x, input int n, input int h);
      hst.xfer(x, n, h);
      repeat (12) @(posedge sys_clk);
      #1;
   endtask

   task automatic cmp_all();
      check(input_code, exp_in);
      check(dac_code, exp_dac);
      check(48'(powered_up), 48'(exp_pu));
   endtask

   task automatic conclude();
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   initial begin
      #300000;
      n_mismatch++;
      conclude();
   end

   initial begin
      nrst = 1'b0;
      apply_hold = 1'b0;
      exp_in = '0;
      exp_dac = '0;
      exp_pu = 1'b0;
      void'($urandom(29761));
      repeat (4) @(posedge sys_clk);
      #1 nrst = 1'b1;
      @(posedge sys_clk);
      #1;
      cmp_all();
      check(48'(word_pending), 48'h0);
      repeat (4) @(posedge sys_clk);
      #1;
      for (int i = 0; i < 24; i++) begin
         w = mk(2'(i), 1'($urandom), 1'($urandom), 12'($urandom));
         if (i == 0) w = mk(2'h0, 1'b1, 1'b1, 12'h800);
         if (i == 23) w = mk(2'h3, 1'b0, 1'b1, 12'h001);
         // One frame runs just under the fastest accepted serial clock.
         send(w, 16, (i == 22) ? 17 : 80);
         upd(w);
         cmp_all();
         check(48'(frame_short), 48'h0);
         check(48'(rate_fault), 48'h0);
      end
      // Fifteen and seventeen bit frames must leave every code alone.
      for (int k = 15; k < 18; k += 2) begin
         send(mk(2'h1, 1'b1, 1'b1, ~exp_in[1]), k, 80);
         check(48'(frame_short), 48'h1);
         cmp_all();
      end
      send(17'h0ffff, 4, 8);
      check(48'(rate_fault), 48'h1);
      cmp_all();
      apply_hold = 1'b1;
      for (int k = 0; k < 3; k++) begin
         w = mk(2'(k), 1'($urandom), 1'(k), 12'($urandom));
         send(w, 16, 80);
         if (k < 2) hw[k] = w;
      end
      check(48'(rate_fault), 48'h0);
      check(48'(frame_dropped), 48'h1);
      check(48'(word_pending), 48'h1);
      cmp_all();
      apply_hold = 1'b0;
      upd(hw[0]);
      upd(hw[1]);
      repeat (6) @(posedge sys_clk);
      #1;
      cmp_all();
      check(48'(word_pending), 48'h0);
      conclude();
   end
endmodule // qdw_dac_serial_bench
